// ### hw/dac_regs_pkg.sv
/*
  Constants, field layouts and types of the converter register bank.
  Assumes an APB master with 32-bit data; each printed offset is a word index.
*/
// Contract
// - reserved bits of every register read back as zero.
// - byte, halfword and word accesses work; each data byte reachable alone.
// - protectable registers ignore writes while the peripheral is locked.
// - standby-keep bit applies at once, without synchronisation delay.
// - enable reads back at once; busy clears when enable takes effect.
// - writing one to soft reset restores all registers, converter off.
// - a write setting soft reset discards its other bits.
// - soft reset bit and busy fall together when reset completes.
// - reference select codes internal 1V, supply, external pin, reserved.
// - bypass bit keeps the data buffer writable while locked.
// - pump disable bit forces the pump off, else automatic.
// - align bit picks right or left placement of 10-bit value.
// - internal output enable routes the output to the comparator.
// - sync access while busy stalls the bus until busy clears.
// - sync ready flag set on busy falling, except enable or reset.
package dac_regs_pkg;

  localparam int PADDR_W = 6;
  localparam int IDX_W   = 4;
  localparam int IDX_LSB = 2;

  localparam logic [IDX_W-1:0] IDX_CTRL    = 4'h0;
  localparam logic [IDX_W-1:0] IDX_CFG     = 4'h1;
  localparam logic [IDX_W-1:0] IDX_EVENT_CONTROL  = 4'h2;
  localparam logic [IDX_W-1:0] IDX_IEN_CLR = 4'h4;
  localparam logic [IDX_W-1:0] IDX_IEN_SET = 4'h5;
  localparam logic [IDX_W-1:0] IDX_IFLAG   = 4'h6;
  localparam logic [IDX_W-1:0] IDX_STATUS  = 4'h7;
  localparam logic [IDX_W-1:0] IDX_DATA    = 4'h8;
  localparam logic [IDX_W-1:0] IDX_DATA_HI = 4'h9;
  localparam logic [IDX_W-1:0] IDX_BUF     = 4'hC;
  localparam logic [IDX_W-1:0] IDX_BUF_HI  = 4'hD;

  localparam logic [7:0] CTRL_MASK  = 8'h07;
  localparam logic [7:0] CFG_MASK   = 8'hDF;
  localparam logic [7:0] EV_MASK    = 8'h03;
  localparam logic [7:0] IRQ_MASK   = 8'h07;
  localparam logic [7:0] STAT_BUSY  = 8'h80;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [15:0] DATA_RST  = 16'h0000;

  localparam int CONV_W    = 10;
  localparam int DATA_W    = 16;
  localparam int LEFT_LSB  = 6;
  localparam int SYNC_CYC  = 4;

  typedef enum logic [1:0] {
    REF_INTERNAL_ONE_VOLT = 2'h0,
    REF_ANALOG_SUPPLY     = 2'h1,
    REF_EXTERNAL_PIN      = 2'h2,
    REF_RESERVED          = 2'h3
  } ref_sel_t;

  typedef struct packed {
    logic [4:0] rsv;
    logic       keep_output_in_standby;
    logic       enable;
    logic       soft_reset_bit;
  } ctrl_t;

  typedef struct packed {
    ref_sel_t   reference_select;
    logic       rsv;
    logic       buffer_protect_bypass;
    logic       pump_disable;
    logic       left_align;
    logic       internal_output_enable;
    logic       external_output_enable;
  } cfg_t;

  typedef struct packed {
    logic [4:0] rsv;
    logic       sync_ready;
    logic       empty;
    logic       underrun;
  } irq_t;

  typedef enum logic {
    KIND_DATA = 1'b0,
    KIND_CTRL = 1'b1
  } sync_kind_t;

endpackage : dac_regs_pkg

// ### hw/dac_control_registers.sv
/*
  Register bank of the 10-bit converter: APB slave, sync-delay model,
  data buffer handoff, interrupt flags and converter control outputs.
  Assumes all inputs except the start event share pclk.
  A sync access met while busy is stalled, never refused.
  Reserved offsets answer zero without wait states.
*/
module dac_control_registers #(
  parameter int SYNC_CYCLES = dac_regs_pkg::SYNC_CYC
) (
  // clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  // apb slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [dac_regs_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                     pwdata,
  input  wire logic [3:0]                      pstrb,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // system
  input  wire logic                            prot_lock,
  input  wire logic                            standby_sleep,
  input  wire logic                            start_event_in,
  // converter side
  output logic                                 conv_enable,
  output logic      [dac_regs_pkg::CONV_W-1:0]  conv_code,
  output logic      [1:0]                      reference_select,
  output logic                                 pump_on,
  output logic                                 internal_output_enable,
  output logic                                 output_buffer_on,
  output logic                                 keep_output_in_standby,
  output logic                                 buffer_empty_event_out,
  output logic                                 irq
);

  localparam int CNT_W = $clog2(SYNC_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SYNC_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  dac_regs_pkg::ctrl_t      ctrl_r;
  dac_regs_pkg::cfg_t       cfg_r;
  logic [7:0]               ev_r;
  dac_regs_pkg::irq_t       ien_r;
  dac_regs_pkg::irq_t       flag_r;
  logic [15:0]              data_r;
  logic [15:0]              buf_r;
  logic                     buf_full_r;
  logic                     busy_r;
  logic [CNT_W-1:0]         cnt_r;
  dac_regs_pkg::sync_kind_t kind_r;
  logic                     en_eff_r;
  logic                     ev_s1_r;
  logic                     ev_s2_r;
  logic                     ev_prev_r;

  logic [dac_regs_pkg::IDX_W-1:0] idx;
  logic                     is_data;
  logic                     is_buf;
  logic                     hi_alias;
  logic                     need_sync;
  logic                     xfer;
  logic                     wr;
  logic                     rd;
  logic                     wr_ok;
  logic                     sync_start;
  logic                     sync_done;
  logic                     soft_clear;
  logic                     ctrl_wr;
  logic                     ev_pulse;
  logic                     take;
  logic                     moved;
  logic                     short_buf;
  logic [7:0]               wbyte;

  // merge byte lanes into a 16-bit register; hi alias hits the upper byte
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0]  st,
    input logic        hi
  );
    logic [15:0] m;
    m = old;
    if (hi) begin
      if (st[0]) m[15:8] = wd[7:0];
    end else begin
      if (st[0]) m[7:0]  = wd[7:0];
      if (st[1]) m[15:8] = wd[15:8];
    end
    return m;
  endfunction : merge16

  // byte-lane-0 write that lands on one 8-bit register
  function automatic logic lane0_hit(
    input logic                           ok,
    input logic [3:0]                     st,
    input logic [dac_regs_pkg::IDX_W-1:0] at,
    input logic [dac_regs_pkg::IDX_W-1:0] want
  );
    return ok && st[0] && (at == want);
  endfunction : lane0_hit

  // place the 10-bit code from a 16-bit word per the align bit
  function automatic logic [dac_regs_pkg::CONV_W-1:0] align10(
    input logic [15:0] w,
    input logic        left
  );
    return left ? w[dac_regs_pkg::DATA_W-1:dac_regs_pkg::LEFT_LSB]
                : w[dac_regs_pkg::CONV_W-1:0];
  endfunction : align10

  // word index decode
  assign idx      = paddr[dac_regs_pkg::PADDR_W-1:dac_regs_pkg::IDX_LSB];
  assign is_data  = (idx == dac_regs_pkg::IDX_DATA) || (idx == dac_regs_pkg::IDX_DATA_HI);
  assign is_buf   = (idx == dac_regs_pkg::IDX_BUF) || (idx == dac_regs_pkg::IDX_BUF_HI);
  assign hi_alias = (idx == dac_regs_pkg::IDX_DATA_HI) || (idx == dac_regs_pkg::IDX_BUF_HI);
  assign wbyte    = pwdata[7:0];

  // accesses that must wait for the converter domain
  assign need_sync = (pwrite && idx == dac_regs_pkg::IDX_CTRL && pstrb[0])
                   || (pwrite && (is_data || is_buf))
                   || (!pwrite && is_data);

  assign pready  = !(psel && need_sync && busy_r);
  assign pslverr = 1'b0;
  assign xfer    = psel && penable && pready;
  assign wr      = xfer && pwrite;
  assign rd      = xfer && !pwrite;

  // lock gates protectable writes; bypass frees the buffer only
  assign wr_ok = wr && (!prot_lock || (is_buf && cfg_r.buffer_protect_bypass));

  assign ctrl_wr    = lane0_hit(wr_ok, pstrb, idx, dac_regs_pkg::IDX_CTRL);
  assign sync_start = ctrl_wr || (wr_ok && (is_data || is_buf)) || (rd && is_data);
  assign sync_done  = busy_r && (cnt_r == CNT_ZERO);
  assign soft_clear = sync_done && ctrl_r.soft_reset_bit;

  // start event: two-stage sync then rising edge
  assign ev_pulse  = ev_s2_r && !ev_prev_r;
  assign take      = ev_pulse && ev_r[0] && en_eff_r;
  assign moved     = take && buf_full_r;
  assign short_buf = take && !buf_full_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_s1_r   <= 1'b0;
      ev_s2_r   <= 1'b0;
      ev_prev_r <= 1'b0;
    end else begin
      ev_s1_r   <= start_event_in;
      ev_s2_r   <= ev_s1_r;
      ev_prev_r <= ev_s2_r;
    end
  end

  // synchronisation busy counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      cnt_r  <= CNT_ZERO;
      kind_r <= dac_regs_pkg::KIND_DATA;
    end else if (sync_start) begin
      busy_r <= 1'b1;
      cnt_r  <= CNT_LOAD;
      kind_r <= ctrl_wr ? dac_regs_pkg::KIND_CTRL : dac_regs_pkg::KIND_DATA;
    end else if (sync_done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r - CNT_W'(1);
    end
  end

  // control register; reset bit wins over the rest of the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= dac_regs_pkg::ctrl_t'(dac_regs_pkg::BYTE_ZERO);
    end else if (soft_clear) begin
      ctrl_r <= dac_regs_pkg::ctrl_t'(dac_regs_pkg::BYTE_ZERO);
    end else if (ctrl_wr && wbyte[0]) begin
      ctrl_r.soft_reset_bit <= 1'b1;
    end else if (ctrl_wr) begin
      ctrl_r.keep_output_in_standby <= wbyte[2];
      ctrl_r.enable                 <= wbyte[1];
    end
  end

  // effective enable follows after the sync delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_eff_r <= 1'b0;
    end else if (soft_clear) begin
      en_eff_r <= 1'b0;
    end else if (sync_done && kind_r == dac_regs_pkg::KIND_CTRL) begin
      en_eff_r <= ctrl_r.enable;
    end
  end

  // configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= dac_regs_pkg::cfg_t'(dac_regs_pkg::BYTE_ZERO);
    end else if (soft_clear) begin
      cfg_r <= dac_regs_pkg::cfg_t'(dac_regs_pkg::BYTE_ZERO);
    end else if (lane0_hit(wr_ok, pstrb, idx, dac_regs_pkg::IDX_CFG)) begin
      cfg_r <= dac_regs_pkg::cfg_t'(wbyte & dac_regs_pkg::CFG_MASK);
    end
  end

  // event control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_r <= dac_regs_pkg::BYTE_ZERO;
    end else if (soft_clear) begin
      ev_r <= dac_regs_pkg::BYTE_ZERO;
    end else if (lane0_hit(wr_ok, pstrb, idx, dac_regs_pkg::IDX_EVENT_CONTROL)) begin
      ev_r <= wbyte & dac_regs_pkg::EV_MASK;
    end
  end

  // interrupt enables, set and clear views
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_r <= dac_regs_pkg::irq_t'(dac_regs_pkg::BYTE_ZERO);
    end else if (soft_clear) begin
      ien_r <= dac_regs_pkg::irq_t'(dac_regs_pkg::BYTE_ZERO);
    end else if (lane0_hit(wr_ok, pstrb, idx, dac_regs_pkg::IDX_IEN_SET)) begin
      ien_r <= ien_r | dac_regs_pkg::irq_t'(wbyte & dac_regs_pkg::IRQ_MASK);
    end else if (lane0_hit(wr_ok, pstrb, idx, dac_regs_pkg::IDX_IEN_CLR)) begin
      ien_r <= ien_r & ~dac_regs_pkg::irq_t'(wbyte & dac_regs_pkg::IRQ_MASK);
    end
  end

  // sticky flags: read or write-one clears, new events win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= dac_regs_pkg::irq_t'(dac_regs_pkg::BYTE_ZERO);
    end else if (soft_clear) begin
      flag_r <= dac_regs_pkg::irq_t'(dac_regs_pkg::BYTE_ZERO);
    end else begin
      if (rd && idx == dac_regs_pkg::IDX_IFLAG) begin
        flag_r <= dac_regs_pkg::irq_t'(dac_regs_pkg::BYTE_ZERO);
      end else if (lane0_hit(wr_ok, pstrb, idx, dac_regs_pkg::IDX_IFLAG)) begin
        flag_r <= flag_r & ~dac_regs_pkg::irq_t'(wbyte & dac_regs_pkg::IRQ_MASK);
      end else if (wr_ok && is_buf) begin
        flag_r.empty <= 1'b0;
      end
      if (sync_done && kind_r == dac_regs_pkg::KIND_DATA) begin
        flag_r.sync_ready <= 1'b1;
      end
      if (moved) begin
        flag_r.empty <= 1'b1;
      end
      if (short_buf) begin
        flag_r.underrun <= 1'b1;
      end
    end
  end

  // data, buffer and handoff between them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r     <= dac_regs_pkg::DATA_RST;
      buf_r      <= dac_regs_pkg::DATA_RST;
      buf_full_r <= 1'b1;
    end else if (soft_clear) begin
      data_r     <= dac_regs_pkg::DATA_RST;
      buf_r      <= dac_regs_pkg::DATA_RST;
      buf_full_r <= 1'b1;
    end else begin
      if (moved) begin
        data_r     <= buf_r;
        buf_full_r <= 1'b0;
      end else if (wr_ok && is_data) begin
        data_r <= merge16(data_r, pwdata, pstrb, hi_alias);
      end
      if (wr_ok && is_buf) begin
        buf_r      <= merge16(buf_r, pwdata, pstrb, hi_alias);
        buf_full_r <= 1'b1;
      end
    end
  end

  // converter code follows data one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_code <= '0;
    end else begin
      conv_code <= align10(data_r, cfg_r.left_align);
    end
  end

  // one-cycle event on each buffer-to-data move
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_empty_event_out <= 1'b0;
    end else begin
      buffer_empty_event_out <= moved && ev_r[1];
    end
  end

  // analog controls, gated by the effective enable except reference select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_enable            <= 1'b0;
      reference_select       <= dac_regs_pkg::REF_INTERNAL_ONE_VOLT;
      pump_on                <= 1'b0;
      internal_output_enable <= 1'b0;
      output_buffer_on       <= 1'b0;
    end else begin
      conv_enable            <= en_eff_r;
      reference_select       <= cfg_r.reference_select;
      pump_on                <= en_eff_r && !cfg_r.pump_disable;
      internal_output_enable <= en_eff_r && cfg_r.internal_output_enable;
      output_buffer_on       <= en_eff_r && cfg_r.external_output_enable
                                && !(standby_sleep && !ctrl_r.keep_output_in_standby);
    end
  end

  // standby keep is a plain flop, no sync delay
  assign keep_output_in_standby = ctrl_r.keep_output_in_standby;
  // level interrupt: any unmasked sticky flag
  assign irq = |(flag_r & ien_r);

  // read mux; reserved offsets and bits give zero
  always_comb begin
    prdata = '0;
    if (rd) begin
      unique case (idx)
        dac_regs_pkg::IDX_CTRL:    prdata[7:0] = ctrl_r & dac_regs_pkg::CTRL_MASK;
        dac_regs_pkg::IDX_CFG:     prdata[7:0] = cfg_r & dac_regs_pkg::CFG_MASK;
        dac_regs_pkg::IDX_EVENT_CONTROL:  prdata[7:0] = ev_r;
        dac_regs_pkg::IDX_IEN_CLR: prdata[7:0] = ien_r & dac_regs_pkg::IRQ_MASK;
        dac_regs_pkg::IDX_IEN_SET: prdata[7:0] = ien_r & dac_regs_pkg::IRQ_MASK;
        dac_regs_pkg::IDX_IFLAG:   prdata[7:0] = flag_r & dac_regs_pkg::IRQ_MASK;
        dac_regs_pkg::IDX_STATUS:  prdata[7:0] = busy_r ? dac_regs_pkg::STAT_BUSY
                                                        : dac_regs_pkg::BYTE_ZERO;
        dac_regs_pkg::IDX_DATA:    prdata[15:0] = data_r;
        dac_regs_pkg::IDX_DATA_HI: prdata[7:0] = data_r[15:8];
        dac_regs_pkg::IDX_BUF:     prdata[15:0] = buf_r;
        dac_regs_pkg::IDX_BUF_HI:  prdata[7:0] = buf_r[15:8];
        default:                   prdata = '0;
      endcase
    end
  end

endmodule : dac_control_registers

// ### test/dac_regs_props.sv
/*
  Port-level checker for the converter register bank.
  Assumes it is bound to dac_control_registers and sees only its ports.
*/
module dac_regs_props #(
  parameter int SYNC_CYCLES = dac_regs_pkg::SYNC_CYC
) (
  input wire logic                              pclk, presetn, psel, penable, pwrite,
  input wire logic [dac_regs_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0]                       pwdata, prdata,
  input wire logic [3:0]                        pstrb,
  input wire logic                              pready, pslverr, prot_lock, standby_sleep,
  input wire logic                              start_event_in, conv_enable,
  input wire logic [dac_regs_pkg::CONV_W-1:0]  conv_code,
  input wire logic [1:0]                        reference_select,
  input wire logic                              pump_on, internal_output_enable,
  input wire logic                              output_buffer_on, keep_output_in_standby,
  input wire logic                              buffer_empty_event_out, irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       acc;
  logic       wr_ok;
  logic [3:0] idx;
  logic       ctl_wr;
  logic       cfg_wr;
  assign acc    = psel && penable && pready;
  assign idx    = paddr[5:2];
  assign wr_ok  = acc && pwrite && !prot_lock && pstrb[0];
  assign ctl_wr = wr_ok && idx == 4'h0;
  assign cfg_wr = wr_ok && idx == 4'h1;

  property p_keep_now;
    ctl_wr && !pwdata[0] |=> keep_output_in_standby == $past(pwdata[2]);
  endproperty
  a_keep_now: assert property (p_keep_now) else $error("standby keep not immediate");
  property p_buf_standby;
    standby_sleep && !keep_output_in_standby |=> !output_buffer_on;
  endproperty
  a_buf_standby: assert property (p_buf_standby) else $error("buffer on in standby");
  property p_enable_delay;
    ctl_wr && pwdata[1:0] == 2'h2 && !conv_enable |=> !conv_enable [*3] ##[1:8] conv_enable;
  endproperty
  a_enable_delay: assert property (p_enable_delay) else $error("enable sync wrong");
  property p_reset_seq;
    ctl_wr && pwdata[0] && !keep_output_in_standby |=> !keep_output_in_standby [*3]
      ##[1:10] (!conv_enable && !pump_on && reference_select == 2'h0);
  endproperty
  a_reset_seq: assert property (p_reset_seq) else $error("soft reset wrong");
  property p_ref_follow;
    cfg_wr |=> ##1 reference_select == $past(pwdata[7:6], 2);
  endproperty
  a_ref_follow: assert property (p_ref_follow) else $error("reference not applied");
  property p_lock_hold;
    acc && pwrite && prot_lock && idx == 4'h1 |=> ##1 $stable(reference_select);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked write applied");
  property p_pump_off;
    cfg_wr && pwdata[3] |=> ##1 !pump_on;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump not disabled");
  property p_internal_output_enable_off;
    cfg_wr && !pwdata[1] |=> ##1 !internal_output_enable;
  endproperty
  a_internal_output_enable_off: assert property (p_internal_output_enable_off) else $error("internal path on");
  property p_stall_psel;
    !pready |-> psel;
  endproperty
  a_stall_psel: assert property (p_stall_psel) else $error("stall without request");
  property p_stall_bound;
    $fell(pready) |-> ##[1:9] pready;
  endproperty
  a_stall_bound: assert property (p_stall_bound) else $error("stall too long");
  property p_rsv_off;
    acc && !pwrite && (idx == 4'h3 || idx == 4'hA || idx == 4'hB || idx > 4'hD) |-> prdata == 0;
  endproperty
  a_rsv_off: assert property (p_rsv_off) else $error("reserved offset not zero");
  property p_rsv_bits;
    acc && !pwrite && idx < 4'h8 |-> prdata[31:8] == 24'h0;
  endproperty
  a_rsv_bits: assert property (p_rsv_bits) else $error("upper read bits set");
endmodule : dac_regs_props

bind dac_control_registers dac_regs_props #(.SYNC_CYCLES(SYNC_CYCLES)) u_props (.*);

// ### test/testbench.sv
/*
  Self-checking bench for the converter register bank over APB.
  Assumes a single pclk domain; reads are compared by a monitor process.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        prot_lock, standby_sleep, start_event_in, conv_enable, pump_on;
  logic        internal_output_enable, output_buffer_on, keep_output_in_standby;
  logic        buffer_empty_event_out;
  logic [5:0]  paddr;
  logic [31:0] pwdata, prdata, d;
  logic [3:0]  pstrb;
  logic [9:0]  conv_code;
  logic [1:0]  reference_select;
  logic [31:0] exp_q[$];
  int          mismatches, total_checks, waits, ev_pulses;
  int          seed = 91;

  dac_control_registers u_dac_control_registers (.*);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic complete_run();
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
    total_checks++;
    if (a !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, a);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [3:0] i, input logic [31:0] v, input logic [3:0] s);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {i, 2'h0};
    pwdata  <= v;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    waits = 0;
    do begin
      @(posedge pclk);
      waits++;
    end while (pready !== 1'b1 && waits < 40);
    if (waits >= 40) begin
      mismatches++;
      complete_run();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [3:0] i, input logic [31:0] v, input logic [3:0] s = 4'h1);
    apb(1'b1, i, v, s);
  endtask : wr

  task automatic rd(input logic [3:0] i, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, i, 32'h0, 4'h0);
  endtask : rd

  always @(posedge pclk) if (buffer_empty_event_out === 1'b1) ev_pulses++;

  // compares every completed read against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) chk("read queue", 32'h1, 32'h0);
      else chk("prdata", exp_q.pop_front(), prdata);
    end
  end

  initial begin
    {psel, penable, pwrite, prot_lock, standby_sleep, start_event_in} = '0;
    {paddr, pwdata, pstrb} = '0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 16; i++) rd(i[3:0], 32'h0);
    rd(4'h6, 32'h04);
    wr(4'h2, 32'hFF);
    rd(4'h2, 32'h03);
    wr(4'h5, 32'hFF);
    wr(4'h4, 32'h03);
    rd(4'h5, 32'h04);
    for (int r = 0; r < 4; r++) begin
      d = $random(seed);
      d[7:6] = r[1:0];
      d[5] = 1'b0;
      wr(4'h1, d);
      rd(4'h1, {24'h0, d[7:0] & dac_regs_pkg::CFG_MASK});
      chk("reference_select", 32'(r), 32'(reference_select));
    end
    wr(4'h1, 32'h10);
    prot_lock <= 1'b1;
    wr(4'h1, 32'hC0);
    wr(4'h2, 32'h00);
    wr(4'hC, 32'h0123, 4'h3);
    rd(4'h1, 32'h10);
    rd(4'h2, 32'h03);
    prot_lock <= 1'b0;
    wr(4'h0, 32'h02);
    rd(4'h7, 32'h80);
    rd(4'h0, 32'h02);
    repeat (8) @(posedge pclk);
    chk("conv_enable", 32'h1, 32'(conv_enable));
    rd(4'h7, 32'h00);
    rd(4'h6, 32'h04);
    wr(4'h8, 32'h0155, 4'h3);
    wr(4'h9, 32'hAB);
    chk("stall", 32'h1, 32'(waits > 1));
    rd(4'h8, 32'hAB55);
    wr(4'h8, 32'hCD00, 4'h2);
    rd(4'h9, 32'hCD);
    chk("conv_code", 32'h155, 32'(conv_code));
    repeat (6) @(posedge pclk);
    chk("irq", 32'h1, 32'(irq));
    wr(4'h4, 32'h04);
    chk("irq", 32'h0, 32'(irq));
    wr(4'h5, 32'h04);
    chk("irq", 32'h1, 32'(irq));
    rd(4'h6, 32'h04);
    chk("irq", 32'h0, 32'(irq));
    wr(4'h1, 32'h15);
    @(posedge pclk);
    chk("conv_code", 32'h335, 32'(conv_code));
    standby_sleep <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("output_buffer_on", 32'h0, 32'(output_buffer_on));
    wr(4'h0, 32'h06);
    chk("keep_output_in_standby", 32'h1, 32'(keep_output_in_standby));
    repeat (8) @(posedge pclk);
    chk("output_buffer_on", 32'h1, 32'(output_buffer_on));
    standby_sleep <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      start_event_in <= 1'b1;
      repeat (3) @(posedge pclk);
      start_event_in <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    rd(4'h6, 32'h03);
    rd(4'h8, 32'h0123);
    chk("buffer_empty_event_out", 32'h1, 32'(ev_pulses));
    wr(4'h0, 32'h00);
    wr(4'h0, 32'h07);
    rd(4'h0, 32'h01);
    repeat (10) @(posedge pclk);
    for (int i = 0; i < 8; i++) rd(i[3:0], 32'h0);
    chk("conv_enable", 32'h0, 32'(conv_enable));
    complete_run();
  end
endmodule : testbench
